// *** src/dwdg_pkg.sv ***
`default_nettype none

package dwdg_pkg;

   // Register map and field layout
   localparam logic [7:0] WDR_ADDR       = 8'hD8;
   localparam logic [7:0] WDR_RESET      = 8'hFE;
   localparam int         ARM_BIT        = 0;
   localparam int         SOFT_RESET_BIT = 1;
   localparam int         PERIOD_LSB     = 2;
   localparam int         PERIOD_MSB     = 7;

   // Physical counter: bit 6 is the soft reset bit, bits 5..0 the period bits
   localparam logic [6:0] CNT_RESET      = 7'h7F;
   localparam logic [6:0] CNT_EXPIRE     = 7'h40;

   // Timing
   localparam int         CLK_PERIOD_NS  = 10;
   localparam int         PRESCALE_CYCLES = 3072;
   localparam int         STAB_CYCLES    = 2048;

   typedef enum logic [1:0] {
      ST_RUN  = 2'b00,
      ST_WAIT = 2'b01,
      ST_STOP = 2'b10,
      ST_HOLD = 2'b11
   } dwdg_state_type;

endpackage : dwdg_pkg

`default_nettype wire

// *** src/dwdg_prescaler.sv ***
`default_nettype none

module dwdg_prescaler #(
   parameter int DIV = dwdg_pkg::PRESCALE_CYCLES
) (
   // Clock and reset
   input  wire logic   clk_sys_in,
   input  wire logic   rst_n_in,
   // Tick bus
   dwdg_tick_if.pre    tick_bus
);

   localparam int W = $clog2(DIV);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic         tick;
   } dwdg_pre_state_type;

   dwdg_pre_state_type pre_r;
   dwdg_pre_state_type pre_nxt;

   always_comb
   begin
      pre_nxt      = pre_r;
      pre_nxt.tick = 1'b0;
      if (tick_bus.clear)
      begin
         pre_nxt.cnt = '0;
      end
      else if (tick_bus.run)
      begin
         if (pre_r.cnt == W'(DIV - 1))
         begin
            pre_nxt.cnt  = '0;
            pre_nxt.tick = 1'b1;
         end
         else
         begin
            pre_nxt.cnt = pre_r.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         pre_r <= '0;
      end
      else
      begin
         pre_r <= pre_nxt;
      end
   end

   assign tick_bus.tick = pre_r.tick;

endmodule : dwdg_prescaler

`default_nettype wire

// *** src/dwdg_tick_if.sv ***
`default_nettype none

interface dwdg_tick_if;
   logic run;
   logic clear;
   logic tick;

   modport pre (input run, input clear, output tick);
   modport ctl (output run, output clear, input tick);
endinterface : dwdg_tick_if

`default_nettype wire

// *** src/dwdg_top.sv ***
`default_nettype none

// Function
// - Counter expiry while armed raises the internal MCU reset.
// - A register write reloads the counter and restarts the countdown.
// - Two fixed options: hardware/software activation, external stop control.
// - Software activation: disabled until software writes one to the arm bit.
// - Once armed, writes cannot disarm; only an MCU reset does.
// - STOP while disabled enters true stop with the oscillator halted.
// - Hardware option without external control: always on, STOP acts as WAIT.
// - External control while enabled: STOP with NMI low is WAIT, NMI high freezes and stops.
// - Wake from stop resumes counting from the held value.
// - Register at D8 reads FE after reset with software activation: arm clear, rest set.
// - Clearing the soft reset bit resets the MCU at once while the watchdog is enabled.
// - Period bits map reversed: register bit 7 is counter LSB.
// - Reset fires when counter bit 6 falls to zero.
// - Six period bits give 64 timeouts, 3072 to 196608 cycles.
// - Hardware option forces the arm bit high, ignoring writes.
// - Disarmed, the counter runs as a free 7-bit down timer.
// - Watchdog reset reinitialises the counter and holds a stabilisation delay.
// - Reset pin driven low while an internal reset is held.
// - At least 28 instructions run before a reset after activation.
module dwdg_top #(
   parameter int ADDR_W   = 8,
   parameter int PRESCALE = dwdg_pkg::PRESCALE_CYCLES,
   parameter int STAB     = dwdg_pkg::STAB_CYCLES
) (
   // Clock and reset
   input  wire logic              clk_sys_in,
   input  wire logic              rst_n_in,
   // APB slave
   input  wire logic              psel_in,
   input  wire logic              penable_in,
   input  wire logic              pwrite_in,
   input  wire logic [ADDR_W-1:0] paddr_in,
   input  wire logic [31:0]       pwdata_in,
   output logic                   pready_out,
   output logic [31:0]            prdata_out,
   output logic                   pslverr_out,
   // Factory options
   input  wire logic              opt_hw_act_in,
   input  wire logic              opt_ext_stop_in,
   // CPU power control
   input  wire logic              stop_req_in,
   input  wire logic              wake_in,
   input  wire logic              nmi_in,
   // Reset and power outputs
   output logic                   mcu_reset_out,
   output logic                   reset_pin_out,
   output logic                   reset_pin_oe_out,
   output logic                   osc_halt_out,
   output logic                   wait_mode_out
);

   localparam int HW = $clog2(STAB);

   typedef struct packed {
      dwdg_pkg::dwdg_state_type st;
      logic [6:0]               cnt;
      logic                     armed;
      logic [HW-1:0]            hold;
      logic                     nmi_s1;
      logic                     nmi_s2;
      logic                     pready;
      logic                     pslverr;
      logic [31:0]              prdata;
      logic                     rst_req;
      logic                     pin_oe;
      logic                     halt;
      logic                     waitm;
   } dwdg_top_state_type;

   localparam dwdg_top_state_type RST_STATE = '{
      st:      dwdg_pkg::ST_RUN,
      cnt:     dwdg_pkg::CNT_RESET,
      armed:   1'b0,
      hold:    '0,
      nmi_s1:  1'b0,
      nmi_s2:  1'b0,
      pready:  1'b0,
      pslverr: 1'b0,
      prdata:  32'h0000_0000,
      rst_req: 1'b0,
      pin_oe:  1'b0,
      halt:    1'b0,
      waitm:   1'b0
   };

   function automatic logic [5:0] dwdg_rev6(input logic [5:0] x);
      logic [5:0] y;
      y = '0;
      for (int i = 0; i < 6; i++)
      begin
         y[i] = x[5 - i];
      end
      return y;
   endfunction : dwdg_rev6

   // Register byte to physical counter
   function automatic logic [6:0] dwdg_load(input logic [7:0] d);
      return {d[dwdg_pkg::SOFT_RESET_BIT], dwdg_rev6(d[dwdg_pkg::PERIOD_MSB:dwdg_pkg::PERIOD_LSB])};
   endfunction : dwdg_load

   dwdg_top_state_type r;
   dwdg_top_state_type nxt;

   dwdg_tick_if tick_bus ();

   dwdg_prescaler #(
      .DIV (PRESCALE)
   ) u_pre (
      .clk_sys_in (clk_sys_in),
      .rst_n_in   (rst_n_in),
      .tick_bus   (tick_bus)
   );

   logic       enabled;
   logic       access;
   logic       take;
   logic       hit;
   logic       wr_hit;
   logic       arm_new;
   logic       expire;
   logic       clear_pre;
   logic [7:0] reg_view;
   logic [7:0] wdata;

   always_comb
   begin
      nxt         = r;
      nxt.pready  = 1'b0;
      nxt.pslverr = 1'b0;
      nxt.prdata  = 32'h0000_0000;
      nxt.nmi_s1  = nmi_in;
      nxt.nmi_s2  = r.nmi_s1;
      expire      = 1'b0;
      clear_pre   = 1'b0;
      arm_new     = r.armed;
      wdata       = pwdata_in[7:0];

      enabled  = r.armed | opt_hw_act_in;
      reg_view = {dwdg_rev6(r.cnt[5:0]), r.cnt[6], enabled};
      access   = psel_in & penable_in;
      take     = access & r.pready;
      hit      = paddr_in == ADDR_W'(dwdg_pkg::WDR_ADDR);
      wr_hit   = take & hit & pwrite_in;

      // One wait state gives time to register the read data
      if (access && !r.pready)
      begin
         nxt.pready  = 1'b1;
         nxt.pslverr = ~hit;
         if (hit && !pwrite_in)
         begin
            nxt.prdata = {24'h00_0000, reg_view};
         end
      end

      case (r.st)
         dwdg_pkg::ST_HOLD:
         begin
            nxt.cnt   = dwdg_pkg::CNT_RESET;
            nxt.armed = 1'b0;
            clear_pre = 1'b1;
            if (r.hold == '0)
            begin
               nxt.st      = dwdg_pkg::ST_RUN;
               nxt.rst_req = 1'b0;
               nxt.pin_oe  = 1'b0;
            end
            else
            begin
               nxt.hold = r.hold - 1'b1;
            end
         end
         default:
         begin
            // Frozen in stop: ticks are ignored until wake
            if (tick_bus.tick && r.st != dwdg_pkg::ST_STOP)
            begin
               if (enabled && r.cnt == dwdg_pkg::CNT_EXPIRE)
               begin
                  expire = 1'b1;
               end
               else
               begin
                  nxt.cnt = r.cnt - 1'b1;
               end
            end

            if (r.st == dwdg_pkg::ST_RUN && stop_req_in)
            begin
               if (!enabled)
               begin
                  nxt.st = dwdg_pkg::ST_STOP;
               end
               else if (opt_ext_stop_in && r.nmi_s2)
               begin
                  nxt.st = dwdg_pkg::ST_STOP;
               end
               else
               begin
                  nxt.st = dwdg_pkg::ST_WAIT;
               end
            end
            else if (r.st != dwdg_pkg::ST_RUN && wake_in)
            begin
               nxt.st = dwdg_pkg::ST_RUN;
            end

            if (wr_hit)
            begin
               nxt.cnt   = dwdg_load(wdata);
               clear_pre = 1'b1;
               arm_new   = r.armed | wdata[dwdg_pkg::ARM_BIT];
               nxt.armed = arm_new;
               expire    = (arm_new | opt_hw_act_in) & ~wdata[dwdg_pkg::SOFT_RESET_BIT];
            end

            if (expire)
            begin
               nxt.st      = dwdg_pkg::ST_HOLD;
               nxt.hold    = HW'(STAB - 1);
               nxt.rst_req = 1'b1;
               nxt.pin_oe  = 1'b1;
               nxt.cnt     = dwdg_pkg::CNT_RESET;
               nxt.armed   = 1'b0;
               clear_pre   = 1'b1;
            end
         end
      endcase

      nxt.halt  = nxt.st == dwdg_pkg::ST_STOP;
      nxt.waitm = nxt.st == dwdg_pkg::ST_WAIT;
   end

   assign tick_bus.clear = clear_pre;
   assign tick_bus.run   = r.st == dwdg_pkg::ST_RUN || r.st == dwdg_pkg::ST_WAIT;

   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         r <= RST_STATE;
      end
      else
      begin
         r <= nxt;
      end
   end

   assign pready_out       = r.pready;
   assign prdata_out       = r.prdata;
   assign pslverr_out      = r.pslverr;
   assign mcu_reset_out    = r.rst_req;
   assign reset_pin_out    = 1'b0;
   assign reset_pin_oe_out = r.pin_oe;
   assign osc_halt_out     = r.halt;
   assign wait_mode_out    = r.waitm;

   a_expire_reset: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (r.st != dwdg_pkg::ST_HOLD && r.st != dwdg_pkg::ST_STOP && enabled && tick_bus.tick
       && r.cnt == dwdg_pkg::CNT_EXPIRE) |=> mcu_reset_out && r.st == dwdg_pkg::ST_HOLD)
      else $error("expiry did not reset");

   a_reload_value: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (r.st != dwdg_pkg::ST_HOLD && wr_hit && pwdata_in[1]) |=> r.cnt == dwdg_load($past(pwdata_in[7:0])))
      else $error("reload value wrong");

   a_sw_stays_off: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (!opt_hw_act_in && !r.armed && !(wr_hit && pwdata_in[0])) |=> !r.armed)
      else $error("armed without write");

   a_arm_sticky: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (r.armed && r.st != dwdg_pkg::ST_HOLD && !expire) |=> r.armed)
      else $error("watchdog disarmed");

   a_stop_disabled: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (r.st == dwdg_pkg::ST_RUN && stop_req_in && !enabled && !expire) |=> osc_halt_out ##1 osc_halt_out || $past(wake_in))
      else $error("true stop not entered");

   a_stop_as_wait: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (r.st == dwdg_pkg::ST_RUN && stop_req_in && enabled && !opt_ext_stop_in && !expire)
      |=> wait_mode_out && !osc_halt_out)
      else $error("stop not taken as wait");

   a_ext_nmi_stop: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (r.st == dwdg_pkg::ST_RUN && stop_req_in && enabled && opt_ext_stop_in && !expire)
      |=> (osc_halt_out == $past(r.nmi_s2)) && (wait_mode_out == !$past(r.nmi_s2)))
      else $error("nmi stop choice wrong");

   a_stop_frozen: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (r.st == dwdg_pkg::ST_STOP && !wr_hit) |=> $stable(r.cnt))
      else $error("counter moved in stop");

   a_soft_reset: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (r.st != dwdg_pkg::ST_HOLD && wr_hit && (enabled || pwdata_in[0]) && !pwdata_in[1])
      |=> mcu_reset_out)
      else $error("soft reset bit ignored");

   a_hw_arm_read: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (opt_hw_act_in && pready_out && !pslverr_out && $past(!pwrite_in)) |-> prdata_out[0])
      else $error("arm bit not forced");

   a_pin_low: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      mcu_reset_out |-> reset_pin_oe_out && !reset_pin_out)
      else $error("reset pin not driven low");

   a_hold_length: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      $rose(mcu_reset_out) |-> mcu_reset_out [*8])
      else $error("reset hold too short");

   a_reset_value: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      $fell(mcu_reset_out) |-> r.cnt == dwdg_pkg::CNT_RESET && !r.armed)
      else $error("reset value wrong");

   a_timer_wrap: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (!enabled && tick_bus.tick && r.st != dwdg_pkg::ST_STOP && r.st != dwdg_pkg::ST_HOLD
       && r.cnt == 7'h00 && !wr_hit) |=> r.cnt == 7'h7F)
      else $error("timer did not wrap");

   a_reload_quiet: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (r.st != dwdg_pkg::ST_HOLD && wr_hit) |=> !tick_bus.tick)
      else $error("tick right after reload");

   a_armed_msb: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      enabled |-> r.cnt[6])
      else $error("armed counter below expiry");

   a_wait_counts: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (r.st == dwdg_pkg::ST_WAIT && tick_bus.tick && !wr_hit && !expire)
      |=> r.cnt == $past(r.cnt) - 7'h01)
      else $error("counter idle in wait");

   a_wake_resume: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (r.st == dwdg_pkg::ST_STOP && wake_in && !wr_hit)
      |=> !osc_halt_out && $stable(r.cnt))
      else $error("wake did not resume");

endmodule : dwdg_top

`default_nettype wire

// *** testbench/testbench.sv ***
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int PRE  = 8;
   localparam int STAB = 16;

   logic        clk_sys_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic        psel_in = 1'b0;
   logic        penable_in = 1'b0;
   logic        pwrite_in = 1'b0;
   logic [7:0]  paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0000_0000;
   logic        pready_out;
   logic [31:0] prdata_out;
   logic        pslverr_out;
   logic        opt_hw_act_in = 1'b0;
   logic        opt_ext_stop_in = 1'b0;
   logic        stop_req_in = 1'b0;
   logic        wake_in = 1'b0;
   logic        nmi_in = 1'b0;
   logic        mcu_reset_out;
   logic        reset_pin_out;
   logic        reset_pin_oe_out;
   logic        osc_halt_out;
   logic        wait_mode_out;
   int          errors = 0;
   int          compares = 0;
   int          n;
   logic [31:0] rd;
   logic        err;

   dwdg_top #(.ADDR_W(8), .PRESCALE(PRE), .STAB(STAB)) i_dut (
      .clk_sys_in       (clk_sys_in),
      .rst_n_in         (rst_n_in),
      .psel_in          (psel_in),
      .penable_in       (penable_in),
      .pwrite_in        (pwrite_in),
      .paddr_in         (paddr_in),
      .pwdata_in        (pwdata_in),
      .pready_out       (pready_out),
      .prdata_out       (prdata_out),
      .pslverr_out      (pslverr_out),
      .opt_hw_act_in    (opt_hw_act_in),
      .opt_ext_stop_in  (opt_ext_stop_in),
      .stop_req_in      (stop_req_in),
      .wake_in          (wake_in),
      .nmi_in           (nmi_in),
      .mcu_reset_out    (mcu_reset_out),
      .reset_pin_out    (reset_pin_out),
      .reset_pin_oe_out (reset_pin_oe_out),
      .osc_halt_out     (osc_halt_out),
      .wait_mode_out    (wait_mode_out)
   );

   initial
   begin
      forever #5 clk_sys_in = ~clk_sys_in;
   end

   // Register byte from counter period, soft reset and arm bits; period reversed
   function automatic logic [31:0] wdr(input logic [5:0] per, input logic sr, input logic c);
      logic [31:0] r;
      r = 32'h0000_0000;
      for (int k = 0; k < 6; k++) r[7-k] = per[k];
      r[1] = sr;
      r[0] = c;
      return r;
   endfunction : wdr

   task automatic print_verdict;
      if (errors == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int w;
      w = 0;
      @(posedge clk_sys_in);
      psel_in   <= 1'b1;
      pwrite_in <= wr;
      paddr_in  <= a;
      pwdata_in <= wd;
      @(posedge clk_sys_in);
      penable_in <= 1'b1;
      do
      begin
         @(posedge clk_sys_in);
         w++;
      end while (pready_out !== 1'b1 && w < 20);
      if (pready_out !== 1'b1)
      begin
         errors++;
         $display("BAD %0t no bus answer", $time);
      end
      rd  = prdata_out;
      err = pslverr_out;
      psel_in    <= 1'b0;
      penable_in <= 1'b0;
   endtask : apb

   task automatic do_reset(input logic hw, input logic ext);
      rst_n_in        <= 1'b0;
      opt_hw_act_in   <= hw;
      opt_ext_stop_in <= ext;
      repeat (4) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
   endtask : do_reset

   // Ends one edge after the pulse was sampled, so the response is visible
   task automatic pulse(input logic s);
      @(posedge clk_sys_in);
      if (s) stop_req_in <= 1'b1;
      else wake_in <= 1'b1;
      @(posedge clk_sys_in);
      stop_req_in <= 1'b0;
      wake_in     <= 1'b0;
      @(posedge clk_sys_in);
   endtask : pulse

   task automatic wait_rst(input int lim, output int c);
      c = 0;
      while (mcu_reset_out !== 1'b1 && c < lim)
      begin
         @(posedge clk_sys_in);
         c++;
      end
   endtask : wait_rst

   task automatic in_range(input int v, input int lo, input int hi);
      chk({31'h0, (v >= lo && v <= hi)}, 32'h0000_0001);
   endtask : in_range

   initial
   begin
      repeat (20000) @(posedge clk_sys_in);
      errors++;
      print_verdict();
   end

   initial
   begin
      do_reset(1'b0, 1'b0);
      apb(1'b0, 8'hD8, 32'h0);
      chk(rd, 32'h0000_00FE);
      apb(1'b0, 8'h00, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, 8'hD8, wdr(6'h05, 1'b1, 1'b0));
      apb(1'b0, 8'hD8, 32'h0);
      chk(rd, wdr(6'h05, 1'b1, 1'b0));
      // Disarmed counter wraps freely and clearing soft reset is harmless
      apb(1'b1, 8'hD8, wdr(6'h3F, 1'b0, 1'b0));
      wait_rst(1100, n);
      chk(n, 1100);
      pulse(1'b1);
      chk({osc_halt_out, wait_mode_out}, 2'b10);
      pulse(1'b0);
      chk({osc_halt_out, wait_mode_out}, 2'b00);
      apb(1'b1, 8'hD8, wdr(6'h02, 1'b1, 1'b1));
      wait_rst(60, n);
      in_range(n, 3 * PRE - 2, 3 * PRE + 4);
      chk({reset_pin_oe_out, reset_pin_out}, 2'b10);
      wait_rst(0, n);
      n = 0;
      while (mcu_reset_out === 1'b1 && n < 100)
      begin
         @(posedge clk_sys_in);
         n++;
      end
      in_range(n, STAB - 1, STAB + 2);
      apb(1'b0, 8'hD8, 32'h0);
      chk(rd, 32'h0000_00FE);
      apb(1'b1, 8'hD8, wdr(6'h03, 1'b1, 1'b1));
      repeat (2 * PRE) @(posedge clk_sys_in);
      // Reload that also tries to disarm: countdown restarts, stays armed
      apb(1'b1, 8'hD8, wdr(6'h03, 1'b1, 1'b0));
      wait_rst(80, n);
      in_range(n, 4 * PRE - 2, 4 * PRE + 4);
      while (mcu_reset_out === 1'b1) @(posedge clk_sys_in);
      // Shortest period: arming write still allows one full prescale span
      apb(1'b1, 8'hD8, wdr(6'h00, 1'b1, 1'b1));
      wait_rst(40, n);
      in_range(n, PRE, PRE + 4);
      while (mcu_reset_out === 1'b1) @(posedge clk_sys_in);
      apb(1'b1, 8'hD8, wdr(6'h3F, 1'b1, 1'b1));
      apb(1'b1, 8'hD8, wdr(6'h3F, 1'b0, 1'b1));
      wait_rst(4, n);
      chk({31'h0, mcu_reset_out}, 32'h1);

      do_reset(1'b1, 1'b0);
      apb(1'b0, 8'hD8, 32'h0);
      chk(rd, 32'h0000_00FF);
      apb(1'b1, 8'hD8, wdr(6'h01, 1'b1, 1'b0));
      apb(1'b0, 8'hD8, 32'h0);
      chk(rd[0], 1'b1);
      pulse(1'b1);
      chk({osc_halt_out, wait_mode_out}, 2'b01);
      wait_rst(30, n);
      chk({31'h0, mcu_reset_out}, 32'h1);

      do_reset(1'b1, 1'b1);
      apb(1'b1, 8'hD8, wdr(6'h05, 1'b1, 1'b0));
      pulse(1'b1);
      chk({osc_halt_out, wait_mode_out}, 2'b01);
      pulse(1'b0);
      nmi_in <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
      apb(1'b1, 8'hD8, wdr(6'h01, 1'b1, 1'b0));
      pulse(1'b1);
      chk({osc_halt_out, wait_mode_out}, 2'b10);
      wait_rst(200, n);
      chk(n, 200);
      pulse(1'b0);
      chk({31'h0, osc_halt_out}, 32'h0);
      wait_rst(30, n);
      chk({31'h0, mcu_reset_out}, 32'h1);
      print_verdict();
   end

endmodule : testbench

`default_nettype wire
